// File: bench/rlc_host.sv
/*
  Host model: issues byte-wide register writes and reads on the bank's request port.
  Assumes requests are taken at a rising edge and read data lands one cycle later.
*/
module rlc_host
  import rlc_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic [7:0]            reg_rdata_in,
  output rlc_pkg::rlc_reg_req_t      reg_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req_out = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) reg_req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in) reg_req_out <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) reg_req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in) reg_req_out <= '0;
    @(posedge clk_in) d = reg_rdata_in;
  endtask
endmodule

// File: bench/rlc_regs_assertions.sv
/*
  Checker for the retimer link control register bank, watching top-level ports only.
  Assumes a single clock domain and clk_en_in held high by the bench.
*/
module rlc_regs_assertions
  import rlc_pkg::*;
(
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  input wire rlc_pkg::rlc_reg_req_t reg_req_in,
  input wire logic [7:0]            reg_rdata_out,
  input wire logic                  sink_hotplug_input_in,
  input wire logic                  source_hotplug_output_out,
  input wire logic [4:0]            eq_start_db_out,
  input wire logic [1:0]            redrive_retime_select_out,
  input wire logic                  clock_ratio_flag_out,
  input wire logic                  control_channel_training_off_out,
  input wire logic                  mode_commit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // margin covers the ratio register plus the output register
  localparam int LOW_LIM = HPD_LOW_CYC + 8;
  logic [16:0] low_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) low_q <= '0;
    else if (sink_hotplug_input_in) low_q <= '0;
    else if (low_q != '1) low_q <= low_q + 17'h00001;
  end
  property p_hpd_rise; $rose(source_hotplug_output_out) |-> $past(sink_hotplug_input_in); endproperty
  a_hpd_rise: assert property (p_hpd_rise) else $error("hot-plug out rose without sink");
  property p_unmapped; reg_req_in.rd && (reg_req_in.addr > 8'h0C || reg_req_in.addr < 8'h0A)
    |=> reg_rdata_out == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_commit_rd; reg_req_in.rd && reg_req_in.addr == 8'h0A |=> !reg_rdata_out[2]; endproperty
  a_commit_rd: assert property (p_commit_rd) else $error("apply bit read as one");
  property p_res_0b; reg_req_in.rd && reg_req_in.addr == 8'h0B |=> !reg_rdata_out[2]; endproperty
  a_res_0b: assert property (p_res_0b) else $error("reserved bit read as one");
  property p_train; control_channel_training_off_out [*3] |-> clock_ratio_flag_out; endproperty
  a_train: assert property (p_train) else $error("training off without fortieth mode");
  property p_eq_start; eq_start_db_out == EQ_START_SRC || eq_start_db_out == EQ_START_SINK;
  endproperty
  a_eq_start: assert property (p_eq_start) else $error("equalizer start point off");
  property p_mode; $changed(redrive_retime_select_out) |-> mode_commit_out || $past(mode_commit_out);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed without commit");
  property p_ratio_clr; low_q > LOW_LIM && !control_channel_training_off_out
    |-> !clock_ratio_flag_out; endproperty
  a_ratio_clr: assert property (p_ratio_clr) else $error("ratio kept after long unplug");
endmodule

// File: bench/tb_top.sv
/*
  Self-checking bench for the register bank: host tasks, snoop bytes, pin stimulus.
  Assumes a 40 MHz clock and the full 2 ms unplug count of the package.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rlc_pkg::*;
  logic [1:0] slew_s = 2'b10, term_s = 2'b01;
  logic dvi_s = 1'b1;
  logic clk_in = 1'b0, rst_n_in = 1'b0, sel = 1'b1, pd = 1'b0, oe = 1'b1, hp = 1'b1;
  logic aux_up = 1'b0, aux_v = 1'b1, hpo, aux, ratio, toff, commit;
  rlc_reg_req_t req;
  rlc_snoop_t   snp = '0;
  rlc_lane_cfg_t lane;
  logic [7:0] rdata, v;
  logic [4:0] eqs;
  logic [1:0] fm;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  always #12.5 clk_in = ~clk_in;
  rlc_host u_host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_req_out(req));
  rlc_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .reg_req_in(req),
    .reg_rdata_out(rdata), .i2c_config_sel_in(sel), .forced_power_down_in(pd),
    .output_enable_in(oe), .slew_strap_in(slew_s), .link_dvi_strap_in(dvi_s),
    .term_strap_in(term_s), .aux_hw_update_in(aux_up), .aux_hw_value_in(aux_v),
    .sink_hotplug_input_in(hp), .source_hotplug_output_out(hpo),
    .source_side_control_bus_in(snp), .lane_cfg_out(lane), .eq_start_db_out(eqs),
    .aux_bridge_on_out(aux), .redrive_retime_select_out(fm), .clock_ratio_flag_out(ratio),
    .control_channel_training_off_out(toff), .mode_commit_out(commit));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    chk(v, e);
  endtask
  task automatic sbyte(input logic s, input logic [7:0] b);
    @(posedge clk_in) snp <= '{start: s, byte_valid: !s, data: b};
    @(posedge clk_in) snp <= '0;
  endtask
  task automatic w3();
    repeat (3) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 95000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    w3();
    rdc(8'h0A, 8'h39);
    rdc(8'h0B, 8'h00);
    rdc(8'h0C, 8'h00);
    rdc(8'h0D, 8'h00);
    chk(8'(hpo), 8'h01);
    $display("defaults done");
    u_host.wr(8'h0C, 8'hE1);
    w3();
    chk(8'(lane.data_swing), 8'h00);
    rdc(8'h0C, 8'hE1);
    u_host.wr(8'h0A, 8'h3D);
    w3();
    chk(8'({lane.data_swing, lane.deemph}), 8'h1D);
    rdc(8'h0A, 8'h39);
    oe <= 1'b0;
    u_host.wr(8'h0C, 8'h1C);
    w3();
    chk(8'(lane.clk_swing), 8'h07);
    oe <= 1'b1;
    $display("apply done");
    u_host.wr(8'h0B, 8'hF8);
    rdc(8'h0B, 8'hF8);
    u_host.wr(8'h0B, 8'h01);
    w3();
    chk(8'({toff, ratio}), 8'h03);
    u_host.wr(8'h0B, 8'h00);
    sel <= 1'b0;
    u_host.wr(8'h0B, 8'hE0);
    rdc(8'h0B, 8'hAA);
    u_host.wr(8'h0A, 8'h19);
    rdc(8'h0A, 8'h39);
    sel <= 1'b1;
    $display("strap lock done");
    u_host.wr(8'h0A, 8'hBB);
    w3();
    chk(8'(eqs), 8'(EQ_START_SINK));
    chk(8'(fm), 8'h01);
    pd <= 1'b1;
    w3();
    chk(8'(lane), 8'h73);
    chk(8'(lane >> 7), 8'hA8);
    pd <= 1'b0;
    w3();
    chk(8'(fm), 8'h03);
    @(posedge clk_in) {aux_up, aux_v} <= 2'b10;
    @(posedge clk_in) aux_up <= 1'b0;
    w3();
    chk(8'(aux), 8'h00);
    $display("modes done");
    sbyte(1'b1, 8'h00);
    sbyte(1'b0, 8'hA8);
    sbyte(1'b0, SNOOP_OFFSET);
    sbyte(1'b0, 8'h00);
    w3();
    chk(8'(ratio), 8'h00);
    sbyte(1'b1, 8'h00);
    sbyte(1'b0, 8'hA8);
    sbyte(1'b0, SNOOP_OFFSET);
    sbyte(1'b0, 8'h02);
    w3();
    chk(8'(ratio), 8'h01);
    hp <= 1'b0;
    repeat (HPD_LOW_CYC + 20) @(posedge clk_in);
    chk(8'(ratio), 8'h00);
    hp <= 1'b1;
    $display("snoop done");
    final_report();
  end
endmodule
bind rlc_regs rlc_regs_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
  .sink_hotplug_input_in(sink_hotplug_input_in),
  .source_hotplug_output_out(source_hotplug_output_out), .eq_start_db_out(eq_start_db_out),
  .redrive_retime_select_out(redrive_retime_select_out),
  .clock_ratio_flag_out(clock_ratio_flag_out),
  .control_channel_training_off_out(control_channel_training_off_out),
  .mode_commit_out(mode_commit_out));

// File: design/rlc_pkg.sv
/*
  Package for the retimer link control register bank: register offsets, field positions,
  reset values, codes, timing counts and the packed structs that carry lane settings.
  Assumes a 40 MHz system clock and an upstream control-bus slave that presents byte-wide
  register writes and reads by register offset.
*/
package rlc_pkg;

  localparam logic [7:0] REG_MISC_EQ_MODE = 8'h0A;
  localparam logic [7:0] REG_TMDS_OUT     = 8'h0B;
  localparam logic [7:0] REG_SWING_DEEMPH = 8'h0C;

  // 0x0A fields
  localparam int BIT_APP_MODE   = 7;
  localparam int BIT_HPD_BLOCK  = 6;
  localparam int BIT_EQ_ADAPT   = 5;
  localparam int BIT_EQ_ON      = 4;
  localparam int BIT_AUX_ON     = 3;
  localparam int BIT_COMMIT     = 2;
  localparam int LSB_FUNC_MODE  = 0;
  // 0x0B fields
  localparam int LSB_SLEW       = 6;
  localparam int BIT_LINK_DVI   = 5;
  localparam int LSB_TERM       = 3;
  localparam int BIT_RATIO      = 1;
  localparam int BIT_TRAIN_OFF  = 0;
  // 0x0C fields
  localparam int LSB_DSWING     = 5;
  localparam int LSB_CSWING     = 2;
  localparam int LSB_DEEMPH     = 0;

  localparam logic [7:0] MASK_0B = 8'hFB;

  localparam logic       RST_APP_MODE  = 1'b0;
  localparam logic       RST_HPD_BLOCK = 1'b0;
  localparam logic       RST_EQ_ADAPT  = 1'b1;
  localparam logic       RST_EQ_ON     = 1'b1;
  localparam logic       RST_AUX_ON    = 1'b1;
  localparam logic [1:0] RST_FUNC_MODE = 2'h1;
  localparam logic [1:0] RST_SLEW      = 2'h0;
  localparam logic       RST_LINK_DVI  = 1'b0;
  localparam logic [1:0] RST_TERM      = 2'h0;
  localparam logic       RST_RATIO     = 1'b0;
  localparam logic       RST_TRAIN_OFF = 1'b0;
  localparam logic [2:0] RST_SWING     = 3'h0;
  localparam logic [1:0] RST_DEEMPH    = 2'h0;

  // snooped control-channel target
  localparam logic [6:0] SNOOP_ADDR7   = 7'h54; // 0xA8 write address, 7-bit form
  localparam logic [7:0] SNOOP_OFFSET  = 8'h20;
  localparam int         SNOOP_BIT     = 1;

  // equalizer start points, in dB
  localparam logic [4:0] EQ_START_SRC  = 5'h07;
  localparam logic [4:0] EQ_START_SINK = 5'h0D;

  localparam int CLK_HZ        = 40_000_000;
  localparam int HPD_LOW_US    = 2000;
  localparam int HPD_LOW_CYC   = (CLK_HZ / 1_000_000) * HPD_LOW_US + 1;
  localparam int HPD_CNT_W     = 17;

  typedef enum logic [1:0] {
    RLC_FM_REDRIVE, RLC_FM_AUTO_CROSS, RLC_FM_AUTO_V20, RLC_FM_RETIME
  } rlc_func_mode_t;

  typedef struct packed {
    logic [1:0] slew;
    logic       link_dvi;
    logic [1:0] term;
    logic [2:0] data_swing;
    logic [2:0] clk_swing;
    logic [1:0] deemph;
    logic       eq_adapt;
    logic       eq_on;
  } rlc_lane_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rlc_reg_req_t;

  typedef struct packed {
    logic       start;
    logic       byte_valid;
    logic [7:0] data;
  } rlc_snoop_t;

  localparam int SNOOP_IDLE = 0;

endpackage

// File: design/rlc_regs.sv
/*
  Retimer link control register bank (offsets 0x0A..0x0C): holds pending and applied lane
  settings, hot-plug gating, function mode and the snooped clock-ratio flag.
  Assumes the control-bus slave delivers one-cycle write/read strobes with register offset,
  and the source-side bus monitor delivers start and received bytes as one-cycle events.
*/
module rlc_regs
  import rlc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    clk_en_in,
  // register access
  input  wire rlc_pkg::rlc_reg_req_t   reg_req_in,
  output logic [7:0]                   reg_rdata_out,
  // straps and hardware updates
  input  wire logic                    i2c_config_sel_in,
  input  wire logic                    forced_power_down_in,
  input  wire logic                    output_enable_in,
  input  wire logic [1:0]              slew_strap_in,
  input  wire logic                    link_dvi_strap_in,
  input  wire logic [1:0]              term_strap_in,
  input  wire logic                    aux_hw_update_in,
  input  wire logic                    aux_hw_value_in,
  // hot-plug
  input  wire logic                    sink_hotplug_input_in,
  output logic                         source_hotplug_output_out,
  // source-side control bus snoop
  input  wire rlc_pkg::rlc_snoop_t     source_side_control_bus_in,
  // lane controls
  output rlc_pkg::rlc_lane_cfg_t       lane_cfg_out,
  output logic [4:0]                   eq_start_db_out,
  output logic                         aux_bridge_on_out,
  output logic [1:0]                   redrive_retime_select_out,
  output logic                         clock_ratio_flag_out,
  output logic                         control_channel_training_off_out,
  output logic                         mode_commit_out
);
  import rlc_pkg::*;

  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // software-visible fields, plus the applied lane settings and the strap-taken flag
  logic           app_mode_q, hpd_block_q, aux_on_q, train_off_q, ratio_q;
  logic [1:0]     func_mode_q;
  rlc_lane_cfg_t  pend_q, applied_q;
  logic           strap_taken_q;

  wire wr_0a = reg_req_in.wr && reg_req_in.addr == REG_MISC_EQ_MODE;
  wire wr_0b = reg_req_in.wr && reg_req_in.addr == REG_TMDS_OUT;
  wire wr_0c = reg_req_in.wr && reg_req_in.addr == REG_SWING_DEEMPH;
  wire [7:0] wd = reg_req_in.wdata;
  wire sw_ok = i2c_config_sel_in;

  wire commit_wr = wr_0a && wd[BIT_COMMIT];
  // while idle, pending settings flow straight through
  wire idle_link = !output_enable_in || !sink_hotplug_input_in || forced_power_down_in;

  rlc_lane_cfg_t pend_d;
  always_comb begin
    pend_d = pend_q;
    if (!sw_ok) begin
      pend_d.slew     = slew_strap_in;
      pend_d.link_dvi = link_dvi_strap_in;
      pend_d.term     = term_strap_in;
    end
    if (wr_0a && sw_ok) pend_d.eq_adapt = wd[BIT_EQ_ADAPT];
    if (wr_0a) pend_d.eq_on = wd[BIT_EQ_ON];
    if (wr_0b && sw_ok) begin
      pend_d.slew     = wd[LSB_SLEW +: 2];
      pend_d.link_dvi = wd[BIT_LINK_DVI];
      pend_d.term     = wd[LSB_TERM +: 2];
    end
    if (wr_0c) begin
      pend_d.data_swing = wd[LSB_DSWING +: 3];
      // codes 110 and 111 are stored as written; the analog side treats both as -14%
      pend_d.clk_swing  = wd[LSB_CSWING +: 3];
      pend_d.deemph     = wd[LSB_DEEMPH +: 2];
    end
  end

  // hot-plug low timer for the ratio flag
  logic [HPD_CNT_W-1:0] hpd_low_cnt_q;
  wire hpd_low_expired = hpd_low_cnt_q == HPD_CNT_W'(HPD_LOW_CYC);

  // snoop tracker: address byte, offset byte, then data byte
  typedef enum {SN_IDLE, SN_ADDR, SN_OFFS, SN_DATA, SN_SKIP} rlc_snoop_st_t;
  rlc_snoop_st_t sn_q, sn_d;
  wire sn_byte = source_side_control_bus_in.byte_valid;
  wire [7:0] sn_data = source_side_control_bus_in.data;
  wire sn_hit = sn_q == SN_DATA && sn_byte;

  always_comb begin
    sn_d = sn_q;
    case (sn_q)
      SN_IDLE: if (sn_byte) sn_d = SN_SKIP;
      SN_ADDR: if (sn_byte) sn_d = (sn_data == {SNOOP_ADDR7, 1'b0}) ? SN_OFFS : SN_SKIP;
      SN_OFFS: if (sn_byte) sn_d = (sn_data == SNOOP_OFFSET) ? SN_DATA : SN_SKIP;
      SN_DATA: if (sn_byte) sn_d = SN_SKIP;
      SN_SKIP: sn_d = SN_SKIP;
      default: sn_d = SN_IDLE;
    endcase
    if (source_side_control_bus_in.start) sn_d = SN_ADDR;
  end

  logic ratio_d;
  always_comb begin
    ratio_d = ratio_q;
    if (hpd_low_expired) ratio_d = RST_RATIO;
    // a snooped write landing with the unplug clear wins that cycle
    if (sn_hit) ratio_d = sn_data[SNOOP_BIT];
    if (train_off_q) ratio_d = 1'b1;
  end

  // function mode change commits on a power-down or hot-plug toggle
  logic pd_prev_q, hpd_prev_q;
  // first cycle after reset only loads the previous levels, so no false toggle
  wire mode_commit_d = strap_taken_q && ((pd_prev_q != forced_power_down_in)
                     || (hpd_prev_q != sink_hotplug_input_in));

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      app_mode_q    <= RST_APP_MODE;
      hpd_block_q   <= RST_HPD_BLOCK;
      aux_on_q      <= RST_AUX_ON;
      func_mode_q   <= RST_FUNC_MODE;
      train_off_q   <= RST_TRAIN_OFF;
      ratio_q       <= RST_RATIO;
      pend_q        <= '{RST_SLEW, RST_LINK_DVI, RST_TERM, RST_SWING, RST_SWING,
                         RST_DEEMPH, RST_EQ_ADAPT, RST_EQ_ON};
      strap_taken_q <= 1'b0;
      sn_q          <= SN_IDLE;
      hpd_low_cnt_q <= '0;
      pd_prev_q     <= 1'b0;
      hpd_prev_q    <= 1'b0;
    end else if (clk_en_in) begin
      strap_taken_q <= 1'b1;
      pend_q        <= pend_d;
      if (wr_0a) begin
        app_mode_q  <= wd[BIT_APP_MODE];
        hpd_block_q <= wd[BIT_HPD_BLOCK];
        aux_on_q    <= wd[BIT_AUX_ON];
        func_mode_q <= wd[LSB_FUNC_MODE +: 2];
      end else if (aux_hw_update_in) begin
        aux_on_q    <= aux_hw_value_in;
      end
      if (wr_0b) train_off_q <= wd[BIT_TRAIN_OFF];
      ratio_q       <= ratio_d;
      sn_q          <= sn_d;
      if (sink_hotplug_input_in) hpd_low_cnt_q <= '0;
      else if (!hpd_low_expired) hpd_low_cnt_q <= hpd_low_cnt_q + 1'b1;
      pd_prev_q     <= forced_power_down_in;
      hpd_prev_q    <= sink_hotplug_input_in;
    end
  end

  // applied lane settings, plus registered outputs
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      applied_q                        <= '{RST_SLEW, RST_LINK_DVI, RST_TERM, RST_SWING,
                                            RST_SWING, RST_DEEMPH, RST_EQ_ADAPT, RST_EQ_ON};
      lane_cfg_out                     <= '{RST_SLEW, RST_LINK_DVI, RST_TERM, RST_SWING,
                                            RST_SWING, RST_DEEMPH, RST_EQ_ADAPT, RST_EQ_ON};
      source_hotplug_output_out        <= 1'b0;
      eq_start_db_out                  <= EQ_START_SRC;
      aux_bridge_on_out                <= RST_AUX_ON;
      redrive_retime_select_out        <= RST_FUNC_MODE;
      clock_ratio_flag_out             <= RST_RATIO;
      control_channel_training_off_out <= RST_TRAIN_OFF;
      mode_commit_out                  <= 1'b0;
      reg_rdata_out                    <= 8'h00;
    end else if (clk_en_in) begin
      if (commit_wr || idle_link || !strap_taken_q)
        applied_q <= pend_d;
      lane_cfg_out                     <= applied_q;
      source_hotplug_output_out        <= sink_hotplug_input_in && !hpd_block_q;
      eq_start_db_out                  <= app_mode_q ? EQ_START_SINK : EQ_START_SRC;
      aux_bridge_on_out                <= aux_on_q;
      if (mode_commit_d) redrive_retime_select_out <= func_mode_q;
      clock_ratio_flag_out             <= ratio_q;
      control_channel_training_off_out <= train_off_q;
      mode_commit_out                  <= mode_commit_d;
      if (reg_req_in.rd) begin
        case (reg_req_in.addr)
          // commit bit always reads as zero
          REG_MISC_EQ_MODE: reg_rdata_out <= {app_mode_q, hpd_block_q, pend_q.eq_adapt,
                                              pend_q.eq_on, aux_on_q, 1'b0,
                                              func_mode_q};
          REG_TMDS_OUT:     reg_rdata_out <= {pend_q.slew, pend_q.link_dvi, pend_q.term,
                                              1'b0, ratio_q, train_off_q} & MASK_0B;
          REG_SWING_DEEMPH: reg_rdata_out <= {pend_q.data_swing, pend_q.clk_swing,
                                              pend_q.deemph};
          default:          reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

endmodule
